// [logic/iea_defs.svh]
/*
  Constants of the indirect effective-address generator: widths, register
  indices, pointer steps and reset values.
  Assumes it is included by bare name wherever these figures are needed.
*/
`ifndef IEA_DEFS_SVH
`define IEA_DEFS_SVH

`define IEA_AW 16
`define IEA_NREG 16
`define IEA_LITW 10
`define IEA_REG_RST 16'h0000
`define IEA_STEP_BYTE 16'h0001
`define IEA_STEP_WORD 16'h0002
`define IEA_STEP_MAC2 16'h0002
`define IEA_STEP_MAC4 16'h0004
`define IEA_STEP_MAC6 16'h0006
`define IEA_X_PTR0 4'h8
`define IEA_Y_PTR0 4'ha
`define IEA_MAC_OFF 4'hc

`endif

// [logic/iea_pkg.sv]
/*
  Types of the indirect effective-address generator.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package iea_pkg;

  typedef enum logic [2:0] {
    IEA_NOMOD = 3'h0, IEA_PREINC = 3'h1, IEA_PREDEC = 3'h2, IEA_POSTINC = 3'h3,
    IEA_POSTDEC = 3'h4, IEA_REGOFF = 3'h5, IEA_LITOFF = 3'h6
  } iea_mode_t;

  typedef enum logic [2:0] {
    IEA_MNONE = 3'h0, IEA_MINC2 = 3'h1, IEA_MINC4 = 3'h2, IEA_MINC6 = 3'h3,
    IEA_MDEC2 = 3'h4, IEA_MDEC4 = 3'h5, IEA_MDEC6 = 3'h6, IEA_MREGOFF = 3'h7
  } iea_mac_t;

  typedef enum logic [1:0] {
    IEA_GENERAL = 2'h0, IEA_MOVE = 2'h1, IEA_ACCDSP = 2'h2, IEA_MAC = 2'h3
  } iea_class_t;

endpackage

// [logic/iea_generator.sv]
/*
  Effective-address generator for register indirect data accesses, holding
  the 16 working registers as flip-flops. Two operand channels per request;
  for multiply-accumulate requests channel 0 is the X prefetch and channel 1
  the Y prefetch.
  Assumes one request per cycle from the decoder, synchronous to clk.
*/
// Notes on behaviour
// RQ1 - No-modify mode: pointer value is the address, pointer stays unchanged.
// RQ2 - Pre-increment: add 1 (byte) or 2 (word), write back, use new value.
// RQ3 - Pre-decrement: subtract 1 (byte) or 2 (word), write back, use new value.
// RQ4 - Post-increment: address with old value, then add 1 or 2.
// RQ5 - Post-decrement: address with old value, then subtract 1 or 2.
// RQ6 - Addresses are byte addresses; word steps are scaled by two.
// RQ7 - Register offset: pointer plus offset register, unscaled, neither changed.
// RQ8 - Pointer update lands in the same cycle as the access.
// RQ9 - Move with literal: pointer plus sign-extended 10-bit literal, unchanged.
// RQ10 - Register offset only for move and accumulator instructions; literal for moves.
// RQ11 - Multiply-accumulate makes independent X and Y addresses in one request.
// RQ12 - Prefetch pointers: none, or post-step up or down by 2, 4 or 6.
// RQ13 - Prefetch steps are always even.
// RQ14 - Prefetch register offset: X is reg 9 plus 12, Y is 11 plus 12.
// RQ15 - X prefetch uses only regs 8 and 9, Y only regs 10 and 11.
// RQ16 - Pointer and offset may be any of the 16 working registers.
// RQ17 - Any byte address 0x0000 to 0xffff is reachable.
// RQ18 - All sums wrap modulo 65536 with no flag.
// RQ19 - Both channel write-backs complete in the same request; on a shared pointer only the channel 1 write-back lands.
`timescale 1ns/1ns
`include "iea_defs.svh"

module iea_generator #(
  parameter int NREG = `IEA_NREG
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Direct register load
  input wire logic loadEn,
  input wire logic [3:0] loadSel,
  input wire logic [`IEA_AW-1:0] loadData,
  // Register read-back
  input wire logic [3:0] rdSel,
  output logic [`IEA_AW-1:0] rdData_q,
  // Address request
  input wire logic opValid,
  input wire iea_pkg::iea_class_t opClass,
  input wire iea_pkg::iea_mode_t [1:0] chMode,
  input wire logic [1:0] chByte,
  input wire logic [1:0][3:0] ptrSel,
  input wire logic [1:0][3:0] offSel,
  input wire logic [1:0][`IEA_LITW-1:0] litOff,
  input wire iea_pkg::iea_mac_t [1:0] macMode,
  input wire logic [1:0] macSel,
  // Address answer
  output logic eaValid_q,
  output logic modeError_q,
  output logic [1:0][`IEA_AW-1:0] effAddr_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [`IEA_AW-1:0] stepOf(iea_pkg::iea_mode_t m, logic isByte);
    logic [`IEA_AW-1:0] s;
    s = isByte ? `IEA_STEP_BYTE : `IEA_STEP_WORD; // RQ6
    if (m == iea_pkg::IEA_PREDEC || m == iea_pkg::IEA_POSTDEC) begin
      s = `IEA_AW'(~s + `IEA_AW'(1));
    end
    return s;
  endfunction

  function automatic logic [`IEA_AW-1:0] macStep(iea_pkg::iea_mac_t m);
    logic [`IEA_AW-1:0] s;
    s = '0;
    unique case (m) // RQ12 RQ13
      iea_pkg::IEA_MINC2, iea_pkg::IEA_MDEC2: s = `IEA_STEP_MAC2;
      iea_pkg::IEA_MINC4, iea_pkg::IEA_MDEC4: s = `IEA_STEP_MAC4;
      iea_pkg::IEA_MINC6, iea_pkg::IEA_MDEC6: s = `IEA_STEP_MAC6;
      iea_pkg::IEA_MNONE, iea_pkg::IEA_MREGOFF: s = '0;
    endcase
    if (m == iea_pkg::IEA_MDEC2 || m == iea_pkg::IEA_MDEC4 || m == iea_pkg::IEA_MDEC6) begin
      s = `IEA_AW'(~s + `IEA_AW'(1));
    end
    return s;
  endfunction

  // Only two pointers per memory can be named, so the restriction holds by construction
  function automatic logic [3:0] macPtr(logic ch, logic sel, iea_pkg::iea_mac_t m);
    logic hi;
    hi = sel | (m == iea_pkg::IEA_MREGOFF); // RQ14
    return (ch ? `IEA_Y_PTR0 : `IEA_X_PTR0) | {3'h0, hi}; // RQ15
  endfunction

  // ----------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------
  logic [NREG-1:0][`IEA_AW-1:0] wreg_q, wreg_d;
  logic [1:0][`IEA_AW-1:0] effAddr_d;
  logic [`IEA_AW-1:0] rdData_d;
  logic eaValid_d, modeError_d, opBad, opGood;
  logic [1:0] wbEn;
  logic [1:0][3:0] wbIdx;
  logic [1:0][`IEA_AW-1:0] wbVal;

  always_comb begin
    logic [`IEA_AW-1:0] base;
    base = '0;
    opBad = 1'b0;
    wbEn = '0;
    wbIdx = '0;
    wbVal = '0;
    effAddr_d = effAddr_q;
    for (int c = 0; c < 2; c++) begin
      if (opClass != iea_pkg::IEA_MAC) begin
        if (chMode[c] == iea_pkg::IEA_REGOFF && opClass == iea_pkg::IEA_GENERAL) begin
          opBad = 1'b1; // RQ10
        end
        if (chMode[c] == iea_pkg::IEA_LITOFF && opClass != iea_pkg::IEA_MOVE) begin
          opBad = 1'b1; // RQ10
        end
      end
    end
    opGood = opValid && !opBad;
    for (int c = 0; c < 2; c++) begin
      if (opClass == iea_pkg::IEA_MAC) begin
        // Each prefetch has its own pointer and its own post-update
        wbIdx[c] = macPtr(c[0], macSel[c], macMode[c]); // RQ11
        base = wreg_q[wbIdx[c]];
        effAddr_d[c] = base; // RQ12
        if (macMode[c] == iea_pkg::IEA_MREGOFF) begin
          effAddr_d[c] = `IEA_AW'(base + wreg_q[`IEA_MAC_OFF]); // RQ14 RQ18
        end
        wbVal[c] = `IEA_AW'(base + macStep(macMode[c])); // RQ13 RQ18
        wbEn[c] = macMode[c] != iea_pkg::IEA_MNONE && macMode[c] != iea_pkg::IEA_MREGOFF;
      end else begin
        wbIdx[c] = ptrSel[c]; // RQ16
        base = wreg_q[ptrSel[c]];
        wbVal[c] = `IEA_AW'(base + stepOf(chMode[c], chByte[c])); // RQ6 RQ18
        unique case (chMode[c])
          iea_pkg::IEA_NOMOD: effAddr_d[c] = base; // RQ1
          iea_pkg::IEA_PREINC, iea_pkg::IEA_PREDEC: begin
            effAddr_d[c] = wbVal[c]; // RQ2 RQ3
            wbEn[c] = 1'b1;
          end
          iea_pkg::IEA_POSTINC, iea_pkg::IEA_POSTDEC: begin
            effAddr_d[c] = base; // RQ4 RQ5
            wbEn[c] = 1'b1;
          end
          iea_pkg::IEA_REGOFF: effAddr_d[c] = `IEA_AW'(base + wreg_q[offSel[c]]); // RQ7
          iea_pkg::IEA_LITOFF: begin
            effAddr_d[c] = `IEA_AW'(base + {{(`IEA_AW-`IEA_LITW){litOff[c][`IEA_LITW-1]}},
                                           litOff[c]}); // RQ9
          end
          default: effAddr_d[c] = base;
        endcase
      end
    end
    if (!opGood) begin
      wbEn = '0;
      effAddr_d = effAddr_q;
    end
  end

  // Pointer updates win over a direct load; channel 1 wins a shared pointer
  always_comb begin
    wreg_d = wreg_q;
    if (loadEn) begin
      wreg_d[loadSel] = loadData;
    end
    for (int c = 0; c < 2; c++) begin
      if (wbEn[c]) begin
        wreg_d[wbIdx[c]] = wbVal[c]; // RQ8 RQ19
      end
    end
    eaValid_d = opGood;
    modeError_d = opValid && opBad; // RQ10
    rdData_d = wreg_q[rdSel];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wreg_q <= '{default: `IEA_REG_RST};
      effAddr_q <= '0;
      eaValid_q <= 1'b0;
      modeError_q <= 1'b0;
      rdData_q <= '0;
    end else begin
      wreg_q <= wreg_d;
      effAddr_q <= effAddr_d; // RQ17
      eaValid_q <= eaValid_d;
      modeError_q <= modeError_d;
      rdData_q <= rdData_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Channel 0 pointer touched by nobody else this request
  logic solo0;
  assign solo0 = opGood && opClass != iea_pkg::IEA_MAC && !(loadEn && loadSel == ptrSel[0])
                 && !(wbEn[1] && wbIdx[1] == ptrSel[0]);

  sequence s_req0(iea_pkg::iea_mode_t m);
    solo0 && chMode[0] == m;
  endsequence

  property p_nomod;
    s_req0(iea_pkg::IEA_NOMOD) |=> effAddr_q[0] == $past(wreg_q[ptrSel[0]])
      && wreg_q[$past(ptrSel[0])] == $past(wreg_q[ptrSel[0]]);
  endproperty
  a_nomod: assert property (p_nomod) else $error("no-modify address or pointer wrong"); // RQ1

  property p_preinc;
    s_req0(iea_pkg::IEA_PREINC) |=> effAddr_q[0] == 16'($past(wreg_q[ptrSel[0]])
      + ($past(chByte[0]) ? 16'h0001 : 16'h0002)) && wreg_q[$past(ptrSel[0])] == effAddr_q[0];
  endproperty
  a_preinc: assert property (p_preinc) else $error("pre-increment wrong"); // RQ2

  property p_predec;
    s_req0(iea_pkg::IEA_PREDEC) |=> effAddr_q[0] == 16'($past(wreg_q[ptrSel[0]])
      - ($past(chByte[0]) ? 16'h0001 : 16'h0002)) && wreg_q[$past(ptrSel[0])] == effAddr_q[0];
  endproperty
  a_predec: assert property (p_predec) else $error("pre-decrement wrong"); // RQ3

  property p_postinc;
    s_req0(iea_pkg::IEA_POSTINC) |=> effAddr_q[0] == $past(wreg_q[ptrSel[0]])
      && wreg_q[$past(ptrSel[0])] == 16'(effAddr_q[0] + ($past(chByte[0]) ? 16'h0001 : 16'h0002));
  endproperty
  a_postinc: assert property (p_postinc) else $error("post-increment wrong"); // RQ4

  property p_postdec;
    s_req0(iea_pkg::IEA_POSTDEC) |=> effAddr_q[0] == $past(wreg_q[ptrSel[0]])
      && wreg_q[$past(ptrSel[0])] == 16'(effAddr_q[0] - ($past(chByte[0]) ? 16'h0001 : 16'h0002));
  endproperty
  a_postdec: assert property (p_postdec) else $error("post-decrement wrong"); // RQ5

  property p_regoff;
    s_req0(iea_pkg::IEA_REGOFF) |=>
      effAddr_q[0] == 16'($past(wreg_q[ptrSel[0]]) + $past(wreg_q[offSel[0]]));
  endproperty
  a_regoff: assert property (p_regoff) else $error("register offset address wrong"); // RQ7

  property p_lit;
    s_req0(iea_pkg::IEA_LITOFF) |=> effAddr_q[0] ==
      16'($past(wreg_q[ptrSel[0]]) + {{6{$past(litOff[0][9])}}, $past(litOff[0])});
  endproperty
  a_lit: assert property (p_lit) else $error("literal offset address wrong"); // RQ9

  property p_refuse;
    opValid && opClass == iea_pkg::IEA_GENERAL && chMode[0] == iea_pkg::IEA_REGOFF
      |=> modeError_q && !eaValid_q && effAddr_q == $past(effAddr_q)
      ##1 (!modeError_q || $past(opValid));
  endproperty
  a_refuse: assert property (p_refuse) else $error("illegal mode not refused"); // RQ10

  property p_macoff;
    opGood && opClass == iea_pkg::IEA_MAC && macMode == {iea_pkg::IEA_MREGOFF, iea_pkg::IEA_MREGOFF}
      |=> effAddr_q[0] == 16'($past(wreg_q[9]) + $past(wreg_q[12]))
      && effAddr_q[1] == 16'($past(wreg_q[11]) + $past(wreg_q[12]));
  endproperty
  a_macoff: assert property (p_macoff) else $error("prefetch offset address wrong"); // RQ14

  property p_maceven;
    opGood && opClass == iea_pkg::IEA_MAC && !loadEn |=>
      wreg_q[8][0] == $past(wreg_q[8][0]) && wreg_q[10][0] == $past(wreg_q[10][0]);
  endproperty
  a_maceven: assert property (p_maceven) else $error("odd prefetch step"); // RQ13

  property p_timing;
    opGood |=> eaValid_q;
  endproperty
  a_timing: assert property (p_timing) else $error("address not one cycle after request"); // RQ8

endmodule

// [verif/iea_mem_model.sv]
/*
  Data-memory side of the address generator: counts the accesses made.
  Assumes effAddr_q is sampled only while eaValid_q is high.
*/
`timescale 1ns/1ns

module iea_mem_model (
  // Clock
  input wire logic clk,
  // Accesses from the generator
  input wire logic eaValid_q,
  input wire logic [1:0][15:0] effAddr_q,
  // Bookkeeping
  output int accessCount,
  output logic [15:0] lastAddr
);
  initial accessCount = 0;
  initial lastAddr = 16'h0000;
  // Any byte address is accepted; no decode gaps
  always @(posedge clk) begin
    if (eaValid_q === 1'b1) begin
      accessCount <= accessCount + 2;
      lastAddr <= effAddr_q[1];
    end
  end
endmodule

// [verif/testbench.sv]
/*
  Self-checking bench for the indirect address generator.
  Assumes the design reset clears all working registers.
*/
`timescale 1ns/1ns

module testbench;
  logic clk, rst, loadEn, opValid, eaValid_q, modeError_q;
  logic [3:0] loadSel, rdSel;
  logic [15:0] loadData, rdData_q, lastAddr;
  iea_pkg::iea_class_t opClass;
  iea_pkg::iea_mode_t [1:0] chMode;
  iea_pkg::iea_mac_t [1:0] macMode;
  logic [1:0] chByte, macSel;
  logic [1:0][3:0] ptrSel, offSel;
  logic [1:0][9:0] litOff;
  logic [1:0][15:0] effAddr_q;
  logic [15:0] sh [16];
  int errTotal = 0;
  int cmpCount = 0;
  int accessCount;

  iea_generator dut_u (.clk(clk), .rst(rst), .loadEn(loadEn), .loadSel(loadSel),
    .loadData(loadData), .rdSel(rdSel), .rdData_q(rdData_q), .opValid(opValid),
    .opClass(opClass), .chMode(chMode), .chByte(chByte), .ptrSel(ptrSel), .offSel(offSel),
    .litOff(litOff), .macMode(macMode), .macSel(macSel), .eaValid_q(eaValid_q),
    .modeError_q(modeError_q), .effAddr_q(effAddr_q));
  iea_mem_model mem_u (.clk(clk), .eaValid_q(eaValid_q), .effAddr_q(effAddr_q),
    .accessCount(accessCount), .lastAddr(lastAddr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Driving and judging
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // Loads stay high back to back so no strobe is driven twice in one step
  task automatic ld(input int r, input logic [15:0] v);
    opValid = 1'b0;
    loadEn = 1'b1;
    loadSel = 4'(r);
    loadData = v;
    sh[r] = v;
    tick();
  endtask
  task automatic rd(input int r);
    opValid = 1'b0;
    loadEn = 1'b0;
    rdSel = 4'(r);
    tick();
    chk(rdData_q, sh[r]);
  endtask
  task automatic go(input logic ok, input logic [15:0] a0, input logic [15:0] a1);
    loadEn = 1'b0;
    opValid = 1'b1;
    tick();
    chk({15'h0, eaValid_q}, {15'h0, ok});
    chk({15'h0, modeError_q}, {15'h0, ~ok});
    chk(effAddr_q[0], a0);
    chk(effAddr_q[1], a1);
  endtask
  function automatic logic [15:0] stp(input int k);
    return (k < 4) ? 16'(2 * k) : 16'(-2 * (k - 3));
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_modes;
    logic [15:0] st, a;
    for (int m = 0; m < 5; m++) begin
      for (int b = 0; b < 2; b++) begin
        ld(1, 16'h0890);
        ld(2, 16'h1234);
        st = b ? 16'h0001 : 16'h0002;
        opClass = iea_pkg::IEA_GENERAL;
        chMode[0] = iea_pkg::iea_mode_t'(m);
        chMode[1] = iea_pkg::IEA_NOMOD;
        chByte = 2'(b);
        ptrSel = {4'h2, 4'h1};
        sh[1] = (m == 1) ? sh[1] + st : (m == 2) ? sh[1] - st : sh[1];
        a = sh[1];
        sh[1] = (m == 3) ? sh[1] + st : (m == 4) ? sh[1] - st : sh[1];
        go(1'b1, a, 16'h1234);
        rd(1);
      end
    end
  endtask
  task automatic t_offsets;
    ld(3, 16'h2300);
    ld(4, 16'h01fe);
    ld(8, 16'h2944);
    ld(5, 16'hffff);
    opClass = iea_pkg::IEA_MOVE;
    chMode = {iea_pkg::IEA_LITOFF, iea_pkg::IEA_REGOFF};
    ptrSel = {4'h8, 4'h3};
    offSel = {4'h0, 4'h4};
    litOff = {10'h200, 10'h000};
    chByte = 2'h0;
    go(1'b1, 16'h24fe, 16'h2744);
    chMode = {iea_pkg::IEA_REGOFF, iea_pkg::IEA_LITOFF};
    ptrSel = {4'h3, 4'h8};
    offSel = {4'h4, 4'h0};
    litOff = {10'h000, 10'h200};
    go(1'b1, 16'h2744, 16'h24fe);
    chMode = {iea_pkg::IEA_LITOFF, iea_pkg::IEA_REGOFF};
    offSel = {4'h0, 4'h4};
    ptrSel = {4'h5, 4'h5};
    litOff = {10'h1ff, 10'h000};
    go(1'b1, 16'h01fd, 16'h01fe);
    opClass = iea_pkg::IEA_GENERAL;
    chMode[0] = iea_pkg::IEA_POSTINC;
    ptrSel = {4'h8, 4'h3};
    go(1'b0, 16'h01fd, 16'h01fe);
    chMode[0] = iea_pkg::IEA_REGOFF;
    go(1'b0, 16'h01fd, 16'h01fe);
    opClass = iea_pkg::IEA_ACCDSP;
    chMode = {iea_pkg::IEA_NOMOD, iea_pkg::IEA_REGOFF};
    go(1'b1, 16'h24fe, 16'h2944);
    rd(3);
    rd(4);
    rd(8);
  endtask
  task automatic t_mac;
    int xi, yi;
    opClass = iea_pkg::IEA_MAC;
    for (int m = 0; m < 7; m++) begin
      ld(8, 16'h1000);
      ld(9, 16'h1100);
      ld(10, 16'h2000);
      ld(11, 16'h0002);
      macMode = {iea_pkg::iea_mac_t'((7 - m) % 7), iea_pkg::iea_mac_t'(m)};
      macSel = 2'(m);
      xi = m[0] ? 9 : 8;
      yi = m[1] ? 11 : 10;
      go(1'b1, sh[xi], sh[yi]);
      sh[xi] += stp(m);
      sh[yi] += stp((7 - m) % 7);
      rd(xi);
      rd(yi);
    end
    ld(12, 16'h0008);
    macMode = {iea_pkg::IEA_MREGOFF, iea_pkg::IEA_MREGOFF};
    macSel = 2'h0;
    go(1'b1, 16'(sh[9] + sh[12]), 16'(sh[11] + sh[12]));
    rd(9);
    rd(11);
  endtask
  task automatic t_dual;
    ld(6, 16'h0000);
    ld(7, 16'h2200);
    opClass = iea_pkg::IEA_GENERAL;
    chMode = {iea_pkg::IEA_PREINC, iea_pkg::IEA_PREDEC};
    chByte = 2'h2;
    ptrSel = {4'h7, 4'h6};
    sh[6] = 16'hfffe;
    sh[7] = 16'h2201;
    go(1'b1, 16'hfffe, 16'h2201);
    rd(6);
    rd(7);
  endtask

  task automatic finalReport;
    $display("Comparisons %0d, mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    errTotal++;
    finalReport();
  end

  initial begin
    {rst, loadEn, opValid, loadSel, rdSel, loadData, chByte, macSel} = '0;
    {ptrSel, offSel, litOff} = '0;
    opClass = iea_pkg::IEA_GENERAL;
    chMode = {iea_pkg::IEA_NOMOD, iea_pkg::IEA_NOMOD};
    macMode = {iea_pkg::IEA_MNONE, iea_pkg::IEA_MNONE};
    foreach (sh[i]) sh[i] = 16'h0000;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(15);
    t_modes();
    t_offsets();
    t_mac();
    t_dual();
    // Two accesses per accepted request: 23 accepted, refusals make none
    chk(16'(accessCount), 16'h002e);
    chk(lastAddr, 16'h2201);
    finalReport();
  end
endmodule
